// File: pxs_host_model.sv
`default_nettype none
module pxs_host_model (
   input wire logic sys_clk,
   input wire logic sdaLine,
   output logic sclOut,
   output logic sdaPull
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int QTR = 6; // quarter bit; the pin sync inside costs 3-4 clocks
   // idle bus: both lines left to their pull-ups
   initial begin
      sclOut = 1'b1;
      sdaPull = 1'b0;
   end
   task automatic waitQ();
      repeat (QTR) @(posedge sys_clk);
   endtask
   // data moves only while the clock is low, sampled mid-high
   task automatic bitIo(input logic b, output logic r);
      sdaPull <= ~b;
      waitQ();
      sclOut <= 1'b1;
      waitQ();
      r = sdaLine;
      waitQ();
      sclOut <= 1'b0;
      waitQ();
   endtask
   // start, also used as repeated start
   task automatic startCond();
      sdaPull <= 1'b0;
      waitQ();
      sclOut <= 1'b1;
      waitQ();
      sdaPull <= 1'b1;
      waitQ();
      sclOut <= 1'b0;
      waitQ();
   endtask
   task automatic stopCond();
      sdaPull <= 1'b1;
      waitQ();
      sclOut <= 1'b1;
      waitQ();
      sdaPull <= 1'b0;
      waitQ();
   endtask
   // msb first; ack is 1 when the device pulled the ninth bit low
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(d[i], r);
      end
      bitIo(1'b1, r);
      ack = ~r;
   endtask
   task automatic recvByte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(1'b1, d[i]);
      end
      bitIo(last, r); // nack only after the final byte
   endtask
   // full low leaves a broken word: stop right after the low byte
   task automatic writeWord(input logic [6:0] addr, input logic [7:0] cmd,
         input logic [15:0] w, input logic full, output logic [3:0] acks);
      acks = 4'h0;
      startCond();
      sendByte({addr, 1'b0}, acks[0]);
      sendByte(cmd, acks[1]);
      sendByte(w[7:0], acks[2]);
      if (full) begin
         sendByte(w[15:8], acks[3]);
      end
      stopCond();
   endtask
   task automatic readWord(input logic [6:0] addr, input logic [7:0] cmd,
         output logic [15:0] w, output logic [2:0] acks);
      startCond();
      sendByte({addr, 1'b0}, acks[0]);
      sendByte(cmd, acks[1]);
      startCond();
      sendByte({addr, 1'b1}, acks[2]);
      recvByte(1'b0, w[7:0]);
      recvByte(1'b1, w[15:8]);
      stopCond();
   endtask
endmodule // pxs_host_model
`default_nettype wire

// File: pxs_pkg.sv
`default_nettype none
package pxs_pkg;
   // command codes of the word-wide register bank
   localparam logic [7:0] CMD_RSVD_A = 8'h00;
   localparam logic [7:0] CMD_RSVD_B = 8'h01;
   localparam logic [7:0] CMD_RSVD_C = 8'h02;
   localparam logic [7:0] CMD_CONF_A = 8'h03;
   localparam logic [7:0] CMD_CONF_B = 8'h04;
   localparam logic [7:0] CMD_CANCEL = 8'h05;
   localparam logic [7:0] CMD_TH_LOW = 8'h06;
   localparam logic [7:0] CMD_TH_HIGH = 8'h07;
   localparam logic [7:0] CMD_RESULT_ONE = 8'h08;
   localparam logic [7:0] CMD_RESULT_TWO = 8'h09;
   localparam logic [7:0] CMD_RESULT_THREE = 8'h0a;
   localparam logic [7:0] CMD_RSVD_D = 8'h0b;
   localparam logic [7:0] CMD_RSVD_E = 8'h0c;
   localparam logic [7:0] CMD_FLAGS = 8'h0d;
   localparam logic [7:0] CMD_IDENTITY = 8'h0e;
   // reset values
   localparam logic [7:0] RST_RSVD_A_LOW = 8'h01;
   localparam logic [7:0] RST_RSVD_A_HIGH = 8'h01;
   localparam logic [7:0] RST_RSVD = 8'h00;
   localparam logic [7:0] RST_CONFIG_ONE = 8'h01;
   localparam logic [7:0] RST_CONFIG_TWO = 8'h00;
   localparam logic [7:0] RST_CONFIG_THREE = 8'h00;
   localparam logic [7:0] RST_EMIT_CUR = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_IDENTITY_HIGH = 8'h00;
   // field positions and bus constants
   localparam int SHUTDOWN_BIT = 0;
   localparam logic [6:0] BUS_ADDR = 7'h41;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] PHASE_CMD = 2'h0;
   localparam logic [1:0] PHASE_LOW = 2'h1;
   localparam logic [1:0] PHASE_HIGH = 2'h2;
   localparam logic [1:0] PHASE_DONE = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
   } pxs_state_type;

   // writable configuration, handed to the measurement engine
   typedef struct packed {
      logic [7:0] senseConfigOne;
      logic [7:0] senseConfigTwo;
      logic [7:0] senseConfigThree;
      logic [7:0] emitterCurrentSelect;
      logic [15:0] cancelLevel;
      logic [15:0] lowThreshold;
      logic [15:0] highThreshold;
   } pxs_config_type;

   // measurement results from the engine
   typedef struct packed {
      logic [15:0] resultOne;
      logic [15:0] resultTwo;
      logic [15:0] resultThree;
   } pxs_result_type;
endpackage
`default_nettype wire

// File: pxs_register_bank.sv
`default_nettype none
module pxs_register_bank #(
   parameter logic [6:0] DEV_ADDR = pxs_pkg::BUS_ADDR,
   parameter logic [7:0] ID_LOW = 8'h5a // arbitrary identity value
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire pxs_pkg::pxs_result_type results,
   input wire logic [7:0] flagSet,
   output pxs_pkg::pxs_config_type sensorConfig,
   output logic sensorShutdown,
   output logic intPending
);
   import pxs_pkg::*;

   // refuse reserved bus addresses
   if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : gAddrCheck
      $error("bus address falls in a reserved range");
   end

   typedef struct packed {
      logic [2:0] sclSync;
      logic [2:0] sdaSync;
      logic scl;
      logic sda;
      pxs_state_type state;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic [7:0] rdHigh;
      logic isRead;
      logic txHigh;
      logic acked;
      logic [1:0] phase;
      logic [7:0] cmd;
      logic [7:0] lowHold;
      logic oe;
      pxs_config_type cfg;
      logic [7:0] flags;
   } pxs_regs_type;

   pxs_regs_type st;
   pxs_regs_type next_st;
   logic [1:0] rstSync;
   logic rstQ;
   logic sclRise, sclFall, startSeen, stopSeen;
   logic commit, flagClear;
   logic [15:0] rdWord;

   // reset released through two flops so every flop of st leaves reset together
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstQ = rstSync[1];

   // edges count only once stages two and three agree
   assign sclRise = (st.sclSync[1] == st.sclSync[2]) && st.sclSync[2] && !st.scl;
   assign sclFall = (st.sclSync[1] == st.sclSync[2]) && !st.sclSync[2] && st.scl;
   assign startSeen = st.scl && (st.sdaSync[1] == st.sdaSync[2]) && !st.sdaSync[2] && st.sda;
   assign stopSeen = st.scl && (st.sdaSync[1] == st.sdaSync[2]) && st.sdaSync[2] && !st.sda;

   // read word for the current command; unmapped codes read zero
   always_comb begin
      case (st.cmd)
         CMD_RSVD_A: rdWord = {RST_RSVD_A_HIGH, RST_RSVD_A_LOW};
         CMD_CONF_A: rdWord = {st.cfg.senseConfigTwo, st.cfg.senseConfigOne};
         CMD_CONF_B: rdWord = {st.cfg.emitterCurrentSelect, st.cfg.senseConfigThree};
         CMD_CANCEL: rdWord = st.cfg.cancelLevel;
         CMD_TH_LOW: rdWord = st.cfg.lowThreshold;
         CMD_TH_HIGH: rdWord = st.cfg.highThreshold;
         CMD_RESULT_ONE: rdWord = results.resultOne;
         CMD_RESULT_TWO: rdWord = results.resultTwo;
         CMD_RESULT_THREE: rdWord = results.resultThree;
         CMD_FLAGS: rdWord = {st.flags, RST_RSVD};
         CMD_IDENTITY: rdWord = {RST_IDENTITY_HIGH, ID_LOW};
         default: rdWord = {RST_RSVD, RST_RSVD};
      endcase
   end

   // bus engine and register bank
   always_comb begin
      next_st = st;
      commit = 1'b0;
      flagClear = 1'b0;
      next_st.sclSync = {st.sclSync[1:0], sclIn};
      next_st.sdaSync = {st.sdaSync[1:0], sdaIn};
      if (st.sclSync[1] == st.sclSync[2]) next_st.scl = st.sclSync[2];
      if (st.sdaSync[1] == st.sdaSync[2]) next_st.sda = st.sdaSync[2];
      case (st.state)
         ST_ADDR, ST_RX: begin
            if (sclRise && st.bitCnt < BITS_PER_BYTE) begin
               next_st.shift = {st.shift[6:0], st.sda};
               next_st.bitCnt = st.bitCnt + 4'h1;
            end else if (sclFall && st.bitCnt == BITS_PER_BYTE) begin
               if (st.state == ST_ADDR) begin
                  // acknowledge only our own address
                  if (st.shift[7:1] == DEV_ADDR) begin
                     next_st.state = ST_ADDR_ACK;
                     next_st.isRead = st.shift[0];
                     next_st.oe = 1'b1;
                  end else begin
                     next_st.state = ST_IDLE;
                  end
               end else begin
                  // command, then low byte, then high byte
                  case (st.phase)
                     PHASE_CMD: next_st.cmd = st.shift;
                     PHASE_LOW: next_st.lowHold = st.shift;
                     PHASE_HIGH: commit = 1'b1;
                     default: ;
                  endcase
                  if (st.phase == PHASE_DONE) begin
                     next_st.state = ST_IDLE; // surplus byte is refused
                  end else begin
                     next_st.state = ST_RX_ACK;
                     next_st.oe = 1'b1;
                     next_st.phase = st.phase + 2'h1;
                  end
               end
            end
         end
         ST_ADDR_ACK: begin
            if (sclFall) begin
               next_st.bitCnt = 4'h0;
               if (st.isRead) begin
                  // whole word captured at once so low and high stay coherent
                  next_st.shift = rdWord[7:0];
                  next_st.rdHigh = rdWord[15:8];
                  next_st.txHigh = 1'b0;
                  next_st.oe = !rdWord[7];
                  next_st.state = ST_TX;
                  flagClear = (st.cmd == CMD_FLAGS);
               end else begin
                  next_st.oe = 1'b0;
                  next_st.phase = PHASE_CMD;
                  next_st.state = ST_RX;
               end
            end
         end
         ST_RX_ACK: begin
            if (sclFall) begin
               next_st.oe = 1'b0;
               next_st.bitCnt = 4'h0;
               next_st.state = ST_RX;
            end
         end
         ST_TX: begin
            if (sclRise) begin
               next_st.bitCnt = st.bitCnt + 4'h1;
            end else if (sclFall) begin
               if (st.bitCnt == BITS_PER_BYTE) begin
                  next_st.oe = 1'b0;
                  next_st.state = ST_TX_ACK;
               end else begin
                  next_st.shift = {st.shift[6:0], 1'b0};
                  next_st.oe = !st.shift[6];
               end
            end
         end
         ST_TX_ACK: begin
            if (sclRise) begin
               next_st.acked = !st.sda;
            end else if (sclFall) begin
               // high byte follows an acked low byte; anything else ends it
               if (st.acked && !st.txHigh) begin
                  next_st.shift = st.rdHigh;
                  next_st.txHigh = 1'b1;
                  next_st.oe = !st.rdHigh[7];
                  next_st.bitCnt = 4'h0;
                  next_st.state = ST_TX;
               end else begin
                  next_st.state = ST_IDLE;
               end
            end
         end
         ST_IDLE: ;
         default: next_st.state = ST_IDLE;
      endcase
      // start and stop override any byte in progress
      if (startSeen) begin
         next_st.state = ST_ADDR;
         next_st.bitCnt = 4'h0;
         next_st.oe = 1'b0;
      end else if (stopSeen) begin
         next_st.state = ST_IDLE;
         next_st.oe = 1'b0;
      end
      // a word lands whole; read-only codes drop it
      if (commit) begin
         case (st.cmd)
            CMD_CONF_A: begin
               next_st.cfg.senseConfigOne = st.lowHold;
               next_st.cfg.senseConfigTwo = st.shift;
            end
            CMD_CONF_B: begin
               next_st.cfg.senseConfigThree = st.lowHold;
               next_st.cfg.emitterCurrentSelect = st.shift;
            end
            CMD_CANCEL: next_st.cfg.cancelLevel = {st.shift, st.lowHold};
            CMD_TH_LOW: next_st.cfg.lowThreshold = {st.shift, st.lowHold};
            CMD_TH_HIGH: next_st.cfg.highThreshold = {st.shift, st.lowHold};
            default: ;
         endcase
      end
      // new events win over the read that clears
      next_st.flags = (flagClear ? RST_FLAGS : st.flags) | flagSet;
   end

   // single register stage; reset values are constants only
   always_ff @(posedge sys_clk or negedge rstQ) begin
      if (!rstQ) begin
         st <= '0;
         st.sclSync <= 3'h7;
         st.sdaSync <= 3'h7;
         st.scl <= 1'b1;
         st.sda <= 1'b1;
         st.state <= ST_IDLE;
         st.cfg.senseConfigOne <= RST_CONFIG_ONE;
         st.cfg.senseConfigTwo <= RST_CONFIG_TWO;
         st.cfg.senseConfigThree <= RST_CONFIG_THREE;
         st.cfg.emitterCurrentSelect <= RST_EMIT_CUR;
         st.cfg.cancelLevel <= RST_WORD;
         st.cfg.lowThreshold <= RST_WORD;
         st.cfg.highThreshold <= RST_WORD;
         st.flags <= RST_FLAGS;
      end else begin
         st <= next_st;
      end
   end

   // outputs; the line is only ever pulled low
   assign sdaOut = 1'b0;
   assign sdaOe = st.oe;
   assign sensorConfig = st.cfg;
   assign sensorShutdown = st.cfg.senseConfigOne[SHUTDOWN_BIT];
   assign intPending = |st.flags;

   // checks
   conf_one_a: assert property (@(posedge sys_clk) disable iff (!rstQ)
      $changed(st.cfg.senseConfigOne) |-> $past(commit) && $past(st.cmd) == CMD_CONF_A)
      else $error("config one changed without a word write");
   conf_two_a: assert property (@(posedge sys_clk) disable iff (!rstQ)
      commit && st.cmd == CMD_CONF_A |=> st.cfg.senseConfigTwo == $past(st.shift))
      else $error("config two not taken from high byte");
   conf_three_a: assert property (@(posedge sys_clk) disable iff (!rstQ)
      commit && st.cmd == CMD_CONF_B |=> st.cfg.senseConfigThree == $past(st.lowHold)
      && st.cfg.emitterCurrentSelect == $past(st.shift))
      else $error("config three or emitter current wrong");
   cancel_word_a: assert property (@(posedge sys_clk) disable iff (!rstQ)
      $changed(st.cfg.cancelLevel) |-> $past(commit) && $past(st.cmd) == CMD_CANCEL)
      else $error("cancellation level changed unexpectedly");
   low_thresh_a: assert property (@(posedge sys_clk) disable iff (!rstQ)
      commit && st.cmd == CMD_TH_LOW |=> st.cfg.lowThreshold[7:0] == $past(st.lowHold)
      && st.cfg.lowThreshold[15:8] == $past(st.shift))
      else $error("low threshold byte order wrong");
   high_thresh_a: assert property (@(posedge sys_clk) disable iff (!rstQ)
      commit && st.cmd == CMD_TH_HIGH
      |=> st.cfg.highThreshold == {$past(st.shift), $past(st.lowHold)})
      else $error("high threshold byte order wrong");
   addr_match_a: assert property (@(posedge sys_clk) disable iff (!rstQ)
      $rose(st.state == ST_ADDR_ACK) |-> st.shift[7:1] == DEV_ADDR && st.oe)
      else $error("acknowledged a foreign address");
   word_order_a: assert property (@(posedge sys_clk) disable iff (!rstQ)
      commit |-> !st.isRead && st.phase == PHASE_HIGH ##1 st.state == ST_RX_ACK)
      else $error("word committed out of sequence");
   flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rstQ)
      flagClear |=> st.flags == $past(flagSet))
      else $error("flag read did not clear or lost an event");
   // before the first clock the reset copy is unknown, so compare only on change
   shutdown_pin_a: assert property (@(posedge sys_clk) disable iff (!rstQ)
      $changed(sensorShutdown) |-> $past(commit) && $past(st.cmd) == CMD_CONF_A
      && sensorShutdown == $past(st.lowHold[0]))
      else $error("shutdown output changed without a config write");
   pending_out_a: assert property (@(posedge sys_clk) disable iff (!rstQ)
      $rose(intPending) |-> $past(flagSet) != 8'h00)
      else $error("pending raised without a flag event");
   ro_ignore_a: assert property (@(posedge sys_clk) disable iff (!rstQ)
      commit && st.cmd >= CMD_RESULT_ONE |=> $stable(st.cfg))
      else $error("read-only write altered configuration");
   write_cov: cover property (@(posedge sys_clk) disable iff (!rstQ)
      commit && st.cmd == CMD_TH_HIGH);
   flag_read_cov: cover property (@(posedge sys_clk) disable iff (!rstQ)
      flagClear && st.flags != 8'h00);
   high_byte_cov: cover property (@(posedge sys_clk) disable iff (!rstQ)
      st.state == ST_TX_ACK && st.acked && !st.txHigh ##1 st.txHigh);
endmodule // pxs_register_bank
`default_nettype wire

// File: test_proximity_sensor_register_map.sv
`default_nettype none
`define CHK(act, expv, msg) begin \
   testsRun++; \
   if ((act) !== (expv)) begin \
      $display("CHECK FAILED at %0t: %s", $time, msg); \
      nMismatch++; \
   end \
end
module test_proximity_sensor_register_map;
   timeunit 1ns;
   timeprecision 1ns;
   import pxs_pkg::*;
   localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary identity value
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic sclOut, sdaPull, sdaOut, sdaOe, sensorShutdown, intPending, sdaLine;
   logic [7:0] flagSet = 8'h00;
   logic [7:0] flagExp = 8'h00;
   logic [3:0] acks;
   logic [7:0] roCodes [5] = '{8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e};
   logic [7:0] surplus [5] = '{{BUS_ADDR, 1'b0}, CMD_CANCEL, 8'h66, 8'h99, 8'ha5};
   logic [4:0] sAcks;
   pxs_result_type results = '0;
   pxs_config_type cfg, exp;
   int nMismatch = 0;
   int testsRun = 0;
   always #10 sys_clk = ~sys_clk;
   // open-drain data wire with pull-up
   assign sdaLine = (sdaPull || (sdaOe && !sdaOut)) ? 1'b0 : 1'b1;
   pxs_register_bank #(.DEV_ADDR(BUS_ADDR), .ID_LOW(ID_VAL)) pxs_register_bank_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .sclIn(sclOut), .sdaIn(sdaLine), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .results(results), .flagSet(flagSet), .sensorConfig(cfg),
      .sensorShutdown(sensorShutdown), .intPending(intPending));
   pxs_host_model pxs_host_model_inst (.sys_clk(sys_clk), .sdaLine(sdaLine),
      .sclOut(sclOut), .sdaPull(sdaPull));
   function automatic logic [15:0] expRead(input logic [7:0] cmd);
      case (cmd)
         CMD_RSVD_A: return {RST_RSVD_A_HIGH, RST_RSVD_A_LOW};
         CMD_CONF_A: return {exp.senseConfigTwo, exp.senseConfigOne};
         CMD_CONF_B: return {exp.emitterCurrentSelect, exp.senseConfigThree};
         CMD_CANCEL: return exp.cancelLevel;
         CMD_TH_LOW: return exp.lowThreshold;
         CMD_TH_HIGH: return exp.highThreshold;
         CMD_RESULT_ONE: return results.resultOne;
         CMD_RESULT_TWO: return results.resultTwo;
         CMD_RESULT_THREE: return results.resultThree;
         CMD_FLAGS: return {flagExp, 8'h00};
         CMD_IDENTITY: return {RST_IDENTITY_HIGH, ID_VAL};
         default: return 16'h0000;
      endcase
   endfunction
   // only the five writable words take host data
   function automatic void applyWrite(input logic [7:0] cmd, input logic [15:0] w);
      case (cmd)
         CMD_CONF_A: {exp.senseConfigTwo, exp.senseConfigOne} = w;
         CMD_CONF_B: {exp.emitterCurrentSelect, exp.senseConfigThree} = w;
         CMD_CANCEL: exp.cancelLevel = w;
         CMD_TH_LOW: exp.lowThreshold = w;
         CMD_TH_HIGH: exp.highThreshold = w;
         default: ;
      endcase
   endfunction
   task automatic wr(input logic [7:0] cmd, input logic [15:0] w);
      pxs_host_model_inst.writeWord(BUS_ADDR, cmd, w, 1'b1, acks);
      applyWrite(cmd, w);
      `CHK(acks, 4'hf, "write not acked")
      `CHK(cfg, exp, "config outputs")
   endtask
   task automatic rd(input logic [7:0] cmd);
      logic [15:0] w;
      logic [15:0] e;
      logic [2:0] a;
      e = expRead(cmd);
      pxs_host_model_inst.readWord(BUS_ADDR, cmd, w, a);
      if (cmd == CMD_FLAGS) begin
         flagExp = 8'h00;
      end
      `CHK(a, 3'h7, "read not acked")
      `CHK(w, e, "read data")
   endtask
   task automatic stopTest();
      if (nMismatch == 0 && testsRun > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // watchdog, about twice the expected run of some 48k clocks
   initial begin
      #1800000;
      nMismatch++;
      stopTest();
   end
   // main sequence
   initial begin
      void'($urandom(52));
      exp = {RST_CONFIG_ONE, RST_CONFIG_TWO, RST_CONFIG_THREE, RST_EMIT_CUR, {3{RST_WORD}}};
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      results <= {16'($urandom()), 16'($urandom()), 16'($urandom())};
      repeat (8) @(posedge sys_clk);
      `CHK(cfg, exp, "reset config")
      `CHK(sensorShutdown, 1'b1, "shutdown default")
      // reserved codes are read, never written; 0x0f is unmapped
      for (int c = 0; c < 16; c++) begin
         rd(8'(c));
      end
      wr(CMD_CONF_A, 16'($urandom()) & 16'hfffe);
      `CHK(sensorShutdown, 1'b0, "not powered on")
      wr(CMD_CONF_A, 16'($urandom()) | 16'h0001);
      `CHK(sensorShutdown, 1'b1, "not shut down")
      for (int c = 3; c < 8; c++) begin
         wr(8'(c), 16'($urandom()));
         rd(8'(c));
      end
      wr(CMD_TH_HIGH, 16'hffff);
      rd(CMD_TH_HIGH);
      foreach (roCodes[i]) begin
         wr(roCodes[i], 16'($urandom()));
         rd(roCodes[i]);
      end
      // foreign address must be ignored
      pxs_host_model_inst.writeWord(BUS_ADDR ^ 7'h03, CMD_TH_LOW, 16'h55aa, 1'b1, acks);
      `CHK(acks[0], 1'b0, "foreign address acked")
      `CHK(cfg, exp, "foreign write landed")
      // stop after the low byte drops the word
      pxs_host_model_inst.writeWord(BUS_ADDR, CMD_TH_LOW, 16'h1234, 1'b0, acks);
      `CHK(cfg, exp, "partial word landed")
      // a byte beyond the word is refused; the word itself still lands
      pxs_host_model_inst.startCond();
      foreach (surplus[i]) begin
         pxs_host_model_inst.sendByte(surplus[i], sAcks[i]);
      end
      pxs_host_model_inst.stopCond();
      applyWrite(CMD_CANCEL, 16'h9966);
      `CHK(sAcks, 5'h0f, "surplus byte acked")
      `CHK(cfg, exp, "word before surplus byte")
      // flag pulse, then a read clears it
      flagExp = 8'($urandom()) | 8'h01;
      flagSet <= flagExp;
      @(posedge sys_clk);
      flagSet <= 8'h00;
      repeat (3) @(posedge sys_clk);
      `CHK(intPending, 1'b1, "no pending after set")
      rd(CMD_FLAGS);
      `CHK(intPending, 1'b0, "pending after read")
      rd(CMD_FLAGS);
      stopTest();
   end
endmodule // test_proximity_sensor_register_map
`default_nettype wire
